// *** pkg/ssb_consts.svh ***
`ifndef SSB_CONSTS_SVH
`define SSB_CONSTS_SVH

// ----------------------------------------------------------------
// array shape
// ----------------------------------------------------------------
`define SSB_AW       19
`define SSB_DW       36
`define SSB_LANES    4
`define SSB_LANE_W   9
`define SSB_BURST_W  2

// ----------------------------------------------------------------
// test port
// ----------------------------------------------------------------
`define SSB_IR_W     2
`define SSB_IR_CAPT  2'h1

`endif

// *** pkg/ssb_pkg.sv ***
`include "ssb_consts.svh"

package ssb_pkg;

  // ----------------------------------------------------------------
  // pin groups
  // ----------------------------------------------------------------
  typedef struct packed {
    logic master_select_n;
    logic secondary_select_hi;
    logic secondary_select_lo_n;
    logic proc_addr_strobe_n;
    logic ctrl_addr_strobe_n;
    logic burst_advance_n;
  } ssb_ctl_t;

  typedef struct packed {
    logic                    write_all_n;
    logic                    byte_group_write_n;
    logic [`SSB_LANES-1:0]   per_byte_write_n;
  } ssb_wr_t;

  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
  } ssb_tap_pins_t;

  // ----------------------------------------------------------------
  // test access port states
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    TAP_RESET  = 4'h0,
    TAP_IDLE   = 4'h1,
    TAP_SEL_DR = 4'h2,
    TAP_CAP_DR = 4'h3,
    TAP_SH_DR  = 4'h4,
    TAP_EX1_DR = 4'h5,
    TAP_PA_DR  = 4'h6,
    TAP_EX2_DR = 4'h7,
    TAP_UP_DR  = 4'h8,
    TAP_SEL_IR = 4'h9,
    TAP_CAP_IR = 4'ha,
    TAP_SH_IR  = 4'hb,
    TAP_EX1_IR = 4'hc,
    TAP_PA_IR  = 4'hd,
    TAP_EX2_IR = 4'he,
    TAP_UP_IR  = 4'hf
  } ssb_tap_t;

endpackage

// *** rtl/ssb_sram.sv ***
// How it works
// - all pins but reset, output enable, snooze, burst order sampled on rising clk
// - address captured only when all selects active and a strobe is low
// - data bus driven only while selected and output enable active
// - master select sampled on strobes; inactive master blocks proc strobe
// - secondary selects sampled on ctrl strobe or master plus proc strobe
// - low proc strobe loads address or, deselected, enters standby
// - low ctrl strobe loads address or, deselected, enters standby
// - low burst advance continues the burst to the next address
// - low write-all writes every bit, else byte group and bytes decide
// - per-byte enables count only with byte group low, write-all high
// - byte group low: any byte low means write, none means read
// - output enable acts without the clock; drive only while reading
// - burst order high selects interleaved, low selects linear
// - burst order pin is pulled up, so open reads interleaved
// - test data out changes on falling test clock edge
// - test data in sampled on rising test clock edge
// - test mode select sampled on rising test clock, steers the tap
// - snooze enters low power, keeps data; tie low when unused
// - burst address advances only with advance low, both strobes high
// - advance and byte enables ignored on the proc strobe edge
// - two low address bits seed a four-step wrapping burst counter
`include "ssb_consts.svh"
module ssb_sram
  import ssb_pkg::*;
(
  input  wire logic                  clk_in,
  input  wire logic                  rst_n_in,
  input  wire ssb_ctl_t              ctl_in,
  input  wire ssb_wr_t               wr_in,
  input  wire logic [`SSB_AW-1:0]    addr_in,
  input  wire logic                  output_enable_n_in,
  input  wire logic                  snooze_in,
  input  wire logic                  burst_order_select_n_in,
  input  wire logic [`SSB_DW-1:0]    dq_in,
  output logic      [`SSB_DW-1:0]    dq_out,
  output logic                       dq_oe_out,
  input  wire ssb_tap_pins_t         tap_in,
  output logic                       tdo_out,
  output logic                       tdo_oe_out
);

  // ----------------------------------------------------------------
  // storage and burst state
  // ----------------------------------------------------------------
  logic [`SSB_DW-1:0]      mem [0:(2**`SSB_AW)-1];
  logic [`SSB_AW-1:0]      base_r;
  logic [`SSB_AW-1:0]      base_nxt;
  logic [`SSB_BURST_W-1:0] cnt_r;
  logic [`SSB_BURST_W-1:0] cnt_nxt;
  logic                    active_r;
  logic                    active_nxt;
  logic                    rd_r;
  logic                    rd_nxt;
  logic                    bw_low_r;
  logic                    bw_low_nxt;

  // ----------------------------------------------------------------
  // cycle decode
  // ----------------------------------------------------------------
  logic                    sel_all;
  logic                    proc_start;
  logic                    ctrl_start;
  logic                    cont_cyc;
  logic                    advance;
  logic                    wr_cyc;
  logic [`SSB_LANES-1:0]   lane_we;
  logic [`SSB_AW-1:0]      eff_addr;
  logic [`SSB_DW-1:0]      wr_mask;
  logic [`SSB_DW-1:0]      cur_word;

  // burst offset from seed and step count
  function automatic logic [`SSB_BURST_W-1:0] burst_lsb(
    input logic [`SSB_BURST_W-1:0] seed,
    input logic [`SSB_BURST_W-1:0] step,
    input logic                    order_n
  );
    // the pad pull-up makes an open pin read high, i.e. interleaved
    if (order_n) begin
      burst_lsb = seed ^ step;
    end else begin
      burst_lsb = seed + step;
    end
  endfunction

  // byte lanes to write: write-all overrides the byte group path
  function automatic logic [`SSB_LANES-1:0] lanes_of(input ssb_wr_t w);
    if (!w.write_all_n) begin
      lanes_of = '1;
    end else if (!w.byte_group_write_n) begin
      lanes_of = ~w.per_byte_write_n;
    end else begin
      lanes_of = '0;
    end
  endfunction

  always_comb begin
    sel_all = !ctl_in.master_select_n && ctl_in.secondary_select_hi &&
              !ctl_in.secondary_select_lo_n;
    // inactive master select blocks the proc strobe
    proc_start = !ctl_in.proc_addr_strobe_n &&
                 !ctl_in.master_select_n;
    // proc strobe wins; a ctrl start needs only that no proc start is taken
    ctrl_start = !ctl_in.ctrl_addr_strobe_n && !proc_start;
    cont_cyc   = !proc_start && ctl_in.ctrl_addr_strobe_n;
    advance    = cont_cyc && active_r && !ctl_in.burst_advance_n &&
                 ctl_in.proc_addr_strobe_n;
  end

  always_comb begin
    lane_we = lanes_of(wr_in);
    if (proc_start) begin
      lane_we = '0;
    end
    wr_cyc = !snooze_in && (lane_we != '0) &&
             ((ctrl_start && sel_all) || (cont_cyc && active_r));
  end

  always_comb begin
    base_nxt   = base_r;
    cnt_nxt    = cnt_r;
    active_nxt = active_r;
    rd_nxt     = rd_r;
    bw_low_nxt = 1'b0;
    if (proc_start || ctrl_start) begin
      if (sel_all) begin
        base_nxt   = addr_in;
        cnt_nxt    = '0;
        active_nxt = 1'b1;
        rd_nxt     = !wr_cyc;
        bw_low_nxt = wr_cyc;
      end else begin
        active_nxt = 1'b0;
        rd_nxt     = 1'b0;
      end
    end else if (active_r) begin
      rd_nxt     = !wr_cyc;
      bw_low_nxt = wr_cyc;
      if (advance) begin
        cnt_nxt = cnt_r + 1'b1;
      end
    end
  end

  always_comb begin
    eff_addr = {base_nxt[`SSB_AW-1:`SSB_BURST_W],
                burst_lsb(base_nxt[`SSB_BURST_W-1:0], cnt_nxt,
                          burst_order_select_n_in)};
  end

  genvar g;
  generate
    for (g = 0; g < `SSB_LANES; g = g + 1) begin : g_lane
      assign wr_mask[g*`SSB_LANE_W +: `SSB_LANE_W] =
        {`SSB_LANE_W{lane_we[g]}};
    end
  endgenerate

  // ----------------------------------------------------------------
  // sequencing
  // ----------------------------------------------------------------
  // snooze freezes the burst and cycle registers, not the tap, so the array and burst keep state
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      base_r   <= '0;
      cnt_r    <= '0;
      active_r <= 1'b0;
      rd_r     <= 1'b0;
      bw_low_r <= 1'b0;
    end else if (!snooze_in) begin
      base_r   <= base_nxt;
      cnt_r    <= cnt_nxt;
      active_r <= active_nxt;
      rd_r     <= rd_nxt;
      bw_low_r <= bw_low_nxt;
    end
  end

  // the array has no reset: contents survive reset and snooze alike
  always_ff @(posedge clk_in) begin
    if (wr_cyc) begin
      mem[eff_addr] <= (mem[eff_addr] & ~wr_mask) | (dq_in & wr_mask);
    end
  end

  // ----------------------------------------------------------------
  // data pins
  // ----------------------------------------------------------------
  // flow-through: the registered address selects the word directly
  always_comb begin
    cur_word = mem[{base_r[`SSB_AW-1:`SSB_BURST_W],
                    burst_lsb(base_r[`SSB_BURST_W-1:0], cnt_r,
                              burst_order_select_n_in)}];
    dq_out    = cur_word;
    // output enable is not registered, so it gates the pins at once
    dq_oe_out = !output_enable_n_in && active_r && rd_r &&
                !bw_low_r && !snooze_in;
  end

  // ----------------------------------------------------------------
  // test access port
  // ----------------------------------------------------------------
  // the test clock is sampled as a plain input; it must run well
  // below clk_in so each level is seen for at least one cycle
  ssb_tap_t              tap_r;
  logic                  tck_d_r;
  logic                  tck_rise;
  logic                  tck_fall;
  logic                  bypass_r;
  logic [`SSB_IR_W-1:0]  ir_r;
  logic                  tdo_r;
  logic                  tdo_oe_r;

  function automatic ssb_tap_t tap_next(input ssb_tap_t s,
                                        input logic tms);
    unique case (s)
      TAP_RESET:  tap_next = tms ? TAP_RESET  : TAP_IDLE;
      TAP_IDLE:   tap_next = tms ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_DR: tap_next = tms ? TAP_SEL_IR : TAP_CAP_DR;
      TAP_CAP_DR: tap_next = tms ? TAP_EX1_DR : TAP_SH_DR;
      TAP_SH_DR:  tap_next = tms ? TAP_EX1_DR : TAP_SH_DR;
      TAP_EX1_DR: tap_next = tms ? TAP_UP_DR  : TAP_PA_DR;
      TAP_PA_DR:  tap_next = tms ? TAP_EX2_DR : TAP_PA_DR;
      TAP_EX2_DR: tap_next = tms ? TAP_UP_DR  : TAP_SH_DR;
      TAP_UP_DR:  tap_next = tms ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_IR: tap_next = tms ? TAP_RESET  : TAP_CAP_IR;
      TAP_CAP_IR: tap_next = tms ? TAP_EX1_IR : TAP_SH_IR;
      TAP_SH_IR:  tap_next = tms ? TAP_EX1_IR : TAP_SH_IR;
      TAP_EX1_IR: tap_next = tms ? TAP_UP_IR  : TAP_PA_IR;
      TAP_PA_IR:  tap_next = tms ? TAP_EX2_IR : TAP_PA_IR;
      TAP_EX2_IR: tap_next = tms ? TAP_UP_IR  : TAP_SH_IR;
      TAP_UP_IR:  tap_next = tms ? TAP_SEL_DR : TAP_IDLE;
    endcase
  endfunction

  always_comb begin
    tck_rise = tap_in.tck && !tck_d_r;
    tck_fall = !tap_in.tck && tck_d_r;
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tck_d_r <= 1'b0;
    end else begin
      tck_d_r <= tap_in.tck;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tap_r <= TAP_RESET;
    end else if (tck_rise) begin
      tap_r <= tap_next(tap_r, tap_in.tms);
    end
  end

  // only the bypass path is modelled behind the instruction register
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      bypass_r <= 1'b0;
      ir_r     <= `SSB_IR_CAPT;
    end else if (tck_rise) begin
      unique case (tap_r)
        TAP_CAP_DR: bypass_r <= 1'b0;
        TAP_SH_DR:  bypass_r <= tap_in.tdi;
        TAP_CAP_IR: ir_r     <= `SSB_IR_CAPT;
        TAP_SH_IR:  ir_r     <= {tap_in.tdi,
                                 ir_r[`SSB_IR_W-1:1]};
        default:    ir_r     <= ir_r;
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tdo_r    <= 1'b0;
      tdo_oe_r <= 1'b0;
    end else if (tck_fall) begin
      tdo_r    <= (tap_r == TAP_SH_IR) ? ir_r[0] : bypass_r;
      tdo_oe_r <= (tap_r == TAP_SH_IR) || (tap_r == TAP_SH_DR);
    end
  end

  assign tdo_out    = tdo_r;
  assign tdo_oe_out = tdo_oe_r;

endmodule

// *** verification/ssb_sram_chk.sv ***
`include "ssb_consts.svh"
module ssb_sram_chk
  import ssb_pkg::*;
(
  input wire logic               clk_in,
  input wire logic               rst_n_in,
  input wire ssb_ctl_t           ctl_in,
  input wire ssb_wr_t            wr_in,
  input wire logic               output_enable_n_in,
  input wire logic               snooze_in,
  input wire ssb_tap_pins_t      tap_in,
  input wire logic [`SSB_DW-1:0] dq_out,
  input wire logic               dq_oe_out,
  input wire logic               tdo_out,
  input wire logic               tdo_oe_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_in);
  endclocking
  default disable iff (!rst_n_in);
  // ----------------------------------------------------------------
  // cycle decode
  // ----------------------------------------------------------------
  logic sel, p_go, c_go, wcyc, susp;
  assign sel = !ctl_in.master_select_n && ctl_in.secondary_select_hi &&
               !ctl_in.secondary_select_lo_n;
  assign p_go = sel && !ctl_in.proc_addr_strobe_n && !snooze_in;
  assign c_go = sel && ctl_in.proc_addr_strobe_n &&
                !ctl_in.ctrl_addr_strobe_n && !snooze_in;
  assign wcyc = !wr_in.write_all_n || (!wr_in.byte_group_write_n &&
                wr_in.per_byte_write_n != 4'hf);
  // suspend with no write: nothing may move the read data
  assign susp = ctl_in.proc_addr_strobe_n && ctl_in.ctrl_addr_strobe_n &&
                ctl_in.burst_advance_n && !wcyc && !snooze_in;
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  oe_gate_a: assert property (dq_oe_out |-> !output_enable_n_in)
    else $error("data driven with output enable off");
  snooze_off_a: assert property (snooze_in |-> !dq_oe_out)
    else $error("data driven in snooze");
  proc_read_a: assert property (
    p_go ##1 (!output_enable_n_in && !snooze_in) |-> dq_oe_out)
    else $error("proc start did not read");
  ctrl_read_a: assert property (
    c_go && !wcyc ##1 (!output_enable_n_in && !snooze_in) |-> dq_oe_out)
    else $error("ctrl start read not driven");
  write_off_a: assert property (c_go && wcyc |=> !dq_oe_out)
    else $error("data driven after write");
  desel_master_a: assert property (
    ctl_in.master_select_n && !ctl_in.ctrl_addr_strobe_n && !snooze_in
    |=> !dq_oe_out)
    else $error("master deselect ignored");
  desel_sec_a: assert property (
    !ctl_in.master_select_n && !ctl_in.proc_addr_strobe_n && !sel &&
    !snooze_in |=> !dq_oe_out)
    else $error("secondary deselect ignored");
  hold_read_a: assert property (
    susp |=> dq_out === $past(dq_out))
    else $error("read data moved in suspend");
  tdo_edge_a: assert property (
    $changed(tdo_out) || $changed(tdo_oe_out) |->
    !$past(tap_in.tck) || !$past(tap_in.tck, 2))
    else $error("test output moved away from falling edge");
endmodule

bind ssb_sram ssb_sram_chk u_chk (
  .clk_in, .rst_n_in, .ctl_in, .wr_in, .output_enable_n_in, .snooze_in,
  .tap_in, .dq_out, .dq_oe_out, .tdo_out, .tdo_oe_out);

// *** verification/ssb_host_model.sv ***
`include "ssb_consts.svh"
module ssb_host_model (
  input  wire logic               clk_in,
  input  wire logic [`SSB_DW-1:0] host_d_in,
  input  wire logic               host_oe_in,
  input  wire logic [`SSB_DW-1:0] dev_q_in,
  input  wire logic               dev_oe_in,
  input  wire logic               lbo_drive_in,
  input  wire logic               lbo_val_in,
  output logic      [`SSB_DW-1:0] dq_bus_out,
  output logic                    lbo_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // shared data bus and burst order pad
  // ----------------------------------------------------------------
  logic [`SSB_DW-1:0] last_r = '0;
  // a floating bus must not echo stale data, so it shows the inverse
  always_ff @(posedge clk_in) begin
    last_r <= dq_bus_out;
  end
  assign dq_bus_out = dev_oe_in ? dev_q_in :
                      host_oe_in ? host_d_in : ~last_r;
  assign lbo_out = lbo_drive_in ? lbo_val_in : 1'b1;
endmodule

// *** verification/ssb_sram_tb.sv ***
`include "ssb_consts.svh"
module ssb_sram_tb
  import ssb_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // stimulus and harness
  // ----------------------------------------------------------------
  // ctrl starts keep the proc strobe high on the same edge
  localparam logic [5:0] PST = 6'h13, CST = 6'h15, STEP = 6'h16;
  localparam logic [5:0] SUS = 6'h17, RD = 6'h3f, WAL = 6'h1f;
  localparam int LIMIT = 3000;
  logic               clk_in = 1'b0, rst_n_in = 1'b0, oe_n = 1'b0;
  logic               zz = 1'b0, hoe = 1'b0, lbo_drv = 1'b0, burst_order_select_n;
  logic               dq_oe_out, tdo_out, tdo_oe_out;
  ssb_ctl_t           ctl = SUS;
  ssb_wr_t            wr = RD;
  ssb_tap_pins_t      tap = '0;
  logic [`SSB_AW-1:0] addr = '0;
  logic [`SSB_DW-1:0] hd = '0, dq_in, dq_out;
  int                 n_fail = 0, checked = 0, cycles = 0;

  always #20 clk_in = ~clk_in;
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == LIMIT) begin
      n_fail++;
      wrap_up();
    end
  end

  ssb_sram dut (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .ctl_in(ctl), .wr_in(wr),
    .addr_in(addr), .output_enable_n_in(oe_n), .snooze_in(zz),
    .burst_order_select_n_in(burst_order_select_n), .dq_in(dq_in), .dq_out(dq_out),
    .dq_oe_out(dq_oe_out), .tap_in(tap), .tdo_out(tdo_out),
    .tdo_oe_out(tdo_oe_out));
  ssb_host_model host (
    .clk_in(clk_in), .host_d_in(hd), .host_oe_in(hoe), .dev_q_in(dq_out),
    .dev_oe_in(dq_oe_out), .lbo_drive_in(lbo_drv), .lbo_val_in(1'b0),
    .dq_bus_out(dq_in), .lbo_out(burst_order_select_n));

  function automatic logic [35:0] pat(input logic [18:0] a);
    return {a[16:0], a};
  endfunction
  task automatic chk(input logic [`SSB_DW-1:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // host drives data only with output enable off, so no bus fight
  task automatic cyc(input logic [5:0] c, w, input logic [18:0] a,
                     input logic [35:0] d, input logic o);
    ctl = c;
    wr = w;
    addr = a;
    hd = d;
    oe_n = o;
    hoe = o;
    @(posedge clk_in);
    #1;
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    repeat (10) @(posedge clk_in);
    #1;
    chk(dq_oe_out, 1'b0);
    chk(tdo_oe_out, 1'b0);
    rst_n_in = 1'b1;
  endtask
  task automatic t_bytes();
    logic [35:0] d1, d2;
    d1 = 36'h1_2345_6789;
    d2 = 36'hf_edcb_a987;
    cyc(CST, WAL, 19'h00100, d1, 1'b1);
    cyc(CST, 6'h2e, 19'h00100, d2, 1'b1);
    cyc(PST, RD, 19'h00100, '0, 1'b0);
    chk(dq_out, (d1 & ~36'h1ff) | (d2 & 36'h1ff));
    chk(dq_oe_out, 1'b1);
    oe_n = 1'b1;
    #1;
    chk(dq_oe_out, 1'b0);
    oe_n = 1'b0;
  endtask
  task automatic t_burst(input logic drv);
    logic [18:0] b;
    logic [1:0]  k;
    b = 19'h00240;
    lbo_drv = drv;
    for (int i = 0; i < 4; i++) begin
      cyc(CST, WAL, b + 19'(i), pat(b + 19'(i)), 1'b1);
    end
    cyc(PST, RD, b + 19'h1, '0, 1'b0);
    for (int i = 0; i < 5; i++) begin
      k = drv ? 2'h1 + 2'(i) : 2'h1 ^ 2'(i);
      chk(dq_out, pat({b[18:2], k}));
      if (i == 1) begin
        cyc(SUS, RD, b, '0, 1'b0);
        chk(dq_out, pat({b[18:2], k}));
      end
      cyc(STEP, RD, b, '0, 1'b0);
    end
  endtask
  task automatic t_refuse();
    logic [18:0] a;
    logic [12:0] row [7];
    a = 19'h00377;
    row = '{{PST, 6'h20, 1'b1}, {6'h32, RD, 1'b1}, {CST, 6'h30, 1'b1},
            {CST, 6'h2f, 1'b1}, {6'h35, RD, 1'b0}, {6'h03, RD, 1'b0},
            {6'h1d, RD, 1'b0}};
    cyc(CST, WAL, a, pat(a), 1'b1);
    foreach (row[i]) begin
      cyc(row[i][12:7], row[i][6:1], a, ~pat(a), 1'b0);
      chk(dq_oe_out, row[i][0]);
      if (row[i][0]) begin
        chk(dq_out, pat(a));
      end
    end
    cyc(PST, RD, a, '0, 1'b0);
    chk(dq_out, pat(a));
  endtask
  task automatic t_snooze();
    zz = 1'b1;
    #1;
    chk(dq_oe_out, 1'b0);
    cyc(CST, WAL, 19'h00377, '0, 1'b1);
    zz = 1'b0;
    cyc(PST, RD, 19'h00377, '0, 1'b0);
    chk(dq_out, pat(19'h00377));
  endtask
  task automatic t_tap();
    logic [3:0] row [18];
    row = '{4'h8, 4'h8, 4'h8, 4'h8, 4'h8, 4'h0, 4'h8, 4'h8, 4'h0,
            4'h3, 4'h2, 4'h8, 4'h8, 4'h8, 4'h0, 4'h2, 4'h7, 4'h8};
    foreach (row[i]) begin
      tap.tms = row[i][3];
      tap.tdi = row[i][2];
      repeat (4) @(posedge clk_in);
      #1;
      tap.tck = 1'b1;
      repeat (4) @(posedge clk_in);
      #1;
      tap.tck = 1'b0;
      repeat (4) @(posedge clk_in);
      #1;
      chk(tdo_oe_out, row[i][1]);
      if (row[i][1]) begin
        chk(tdo_out, row[i][0]);
      end
    end
  endtask

  initial begin
    t_reset();
    t_bytes();
    t_burst(1'b0);
    t_burst(1'b1);
    t_refuse();
    t_snooze();
    t_tap();
    wrap_up();
  end
endmodule
